// *** pkg/pwm_pkg.sv ***
// Constants, codes and phase type shared by the PWM fault, dither and capture logic.
// Assumes one 10 MHz clock and event inputs that arrive asynchronously on pins.
// Behaviour
// - Mode 0 leaves outputs and counter alone; captures still work.
// - Mode 1 ends own on time, waits; release resumes at other dead time.
// - Mode 2 ends on time, runs other cycle, waits; resumes own dead time.
// - Mode 3 finishes on time, repeats other cycle while input active.
// - Mode 4 forces both outputs off while active; counter untouched.
// - Mode 5 affects both outputs; only dead times run while active.
// - Mode 6 ends on time and waits; release restarts at other dead time.
// - Mode 7 stops outputs and counter until restart; restart begins at dead time.
// - Mode 7 stays stopped until restart; input still high stops it again.
// - Mode 8 edge in own on time ends it, continues with other dead time.
// - Mode 9 edge in own on time blanks output for rest of on time.
// - Mode 10 blanks output while active and to end of interrupted on time.
// - Dither accumulates fraction per cycle; overflow adds one cycle to each placed state.
// - Placement selects on time B, on times A+B, dead B, dead A+B.
// - Added cycles: one-ramp 1,1,0,0; two-ramp 1,2,0,0; four-ramp 1,2,1,2; none dual.
// - Placements adding nothing shorten the following state by the same amount.
// - One-ramp dead B overflow lengthens dead B and shortens on time B.
// - Two capture units snapshot the counter on event or software strobe.
// - Low byte read first freezes high byte so the pair is coherent.
// - Capture-on-event enable bit set makes that input's events capture.
// - Each completed capture sets its trigger flag; enable raises interrupt.
// - Software capture strobe starts capture; command ready high means valid.
package pwm_pkg;
    localparam int CNT_W = 16;
    localparam int DIT_W = 8;
    localparam int SYNC_STAGES = 2;
    localparam int CAP_LAT = 2;
    localparam logic [3:0] IM_NONE = 4'h0;
    localparam logic [3:0] IM_JUMP_WAIT = 4'h1;
    localparam logic [3:0] IM_EXEC_WAIT = 4'h2;
    localparam logic [3:0] IM_EXEC_REP = 4'h3;
    localparam logic [3:0] IM_STOP_ALL = 4'h4;
    localparam logic [3:0] IM_DEAD_ONLY = 4'h5;
    localparam logic [3:0] IM_JUMP_ALL = 4'h6;
    localparam logic [3:0] IM_SW_WAIT = 4'h7;
    localparam logic [3:0] IM_EDGE_JUMP = 4'h8;
    localparam logic [3:0] IM_EDGE_BLANK = 4'h9;
    localparam logic [3:0] IM_LEVEL_BLANK = 4'ha;
    localparam logic [1:0] WG_ONE = 2'h0;
    localparam logic [1:0] WG_TWO = 2'h1;
    localparam logic [1:0] WG_FOUR = 2'h2;
    localparam logic [1:0] WG_DUAL = 2'h3;
    localparam logic [1:0] DP_OTB = 2'h0;
    localparam logic [1:0] DP_OTAB = 2'h1;
    localparam logic [1:0] DP_DTB = 2'h2;
    localparam logic [1:0] DP_DTAB = 2'h3;
    localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;
    localparam logic [DIT_W-1:0] RST_ACC = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    typedef enum logic [1:0] {PH_DTA, PH_OTA, PH_DTB, PH_OTB} pwm_phase_e;
endpackage

// *** pkg/pwm_cap_if.sv ***
// Carrier between the PWM core and one capture unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pwm_cap_if;
    import pwm_pkg::*;
    logic trig;
    logic rd_low;
    logic clr;
    logic [CNT_W-1:0] value;
    logic [7:0] low;
    logic [7:0] high;
    logic flag;
    logic busy;
    modport core (output trig, rd_low, clr, value, input low, high, flag, busy);
    modport unit (input trig, rd_low, clr, value, output low, high, flag, busy);
endinterface

// *** logic/pwm_capture.sv ***
// One counter capture unit: snapshot, transfer delay, flag and coherent byte pair.
// Assumes the trigger is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module pwm_capture
(
    input wire logic clk,
    input wire logic rst_n,
    pwm_cap_if.unit cap
);
    import pwm_pkg::*;
    logic [CNT_W-1:0] snap_ff;
    logic [CNT_W-1:0] val_ff;
    logic [CAP_LAT-1:0] pipe_ff;
    logic flag_ff;
    logic [7:0] high_ff;
    logic done;

    assign done = pipe_ff[CAP_LAT-1];
    assign cap.busy = |pipe_ff;
    assign cap.flag = flag_ff;
    assign cap.low = val_ff[7:0];
    assign cap.high = high_ff;

    // Triggers during a transfer are ignored
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pipe_ff <= '0;
            snap_ff <= RST_CNT;
        end
        else
        begin
            pipe_ff <= {pipe_ff[CAP_LAT-2:0], cap.trig & ~cap.busy};
            if (cap.trig && !cap.busy)
                snap_ff <= cap.value;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            val_ff <= RST_CNT;
        else if (done)
            val_ff <= snap_ff;
    end

    // Set wins over clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flag_ff <= 1'b0;
        else if (done)
            flag_ff <= 1'b1;
        else if (cap.clr)
            flag_ff <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            high_ff <= RST_BYTE;
        else if (cap.rd_low)
            high_ff <= val_ff[15:8];
    end

    // Flag and value land on the edge after done, one past the transfer delay
    cap_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cap.trig && !cap.busy) |-> ##3 flag_ff && val_ff == $past(cap.value, 3))
        else $error("capture did not complete in time");
    cap_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
        cap.rd_low |=> high_ff == $past(val_ff[15:8]))
        else $error("high byte not frozen by low read");
    cov_cap: cover property (@(posedge clk) disable iff (!rst_n) done && cap.clr);
endmodule // pwm_capture

// *** logic/pwm_fault_dither_capture.sv ***
// PWM phase sequencer with input fault modes, dither and two capture units.
// Assumes event pins are asynchronous and control ports are static or single-cycle.
`timescale 1ns/1ps
module pwm_fault_dither_capture
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic event_a_pin,
    input wire logic event_b_pin,
    input wire logic [3:0] input_mode_select_a,
    input wire logic [3:0] input_mode_select_b,
    input wire logic [1:0] wave_gen,
    input wire logic [pwm_pkg::CNT_W-1:0] dead_a_len,
    input wire logic [pwm_pkg::CNT_W-1:0] on_a_len,
    input wire logic [pwm_pkg::CNT_W-1:0] dead_b_len,
    input wire logic [pwm_pkg::CNT_W-1:0] on_b_len,
    input wire logic [1:0] dither_placement,
    input wire logic [pwm_pkg::DIT_W-1:0] dither_step,
    input wire logic [1:0] capture_on_event,
    input wire logic [1:0] software_capture_strobe,
    input wire logic restart_cmd,
    input wire logic [1:0] trigger_clear,
    input wire logic [1:0] trigger_irq_enable,
    input wire logic [1:0] capture_low_read,
    output logic wave_out_a,
    output logic wave_out_b,
    output logic command_ready,
    output logic trigger_flag_a,
    output logic trigger_flag_b,
    output logic trigger_irq,
    output logic [7:0] capture_a_low,
    output logic [7:0] capture_a_high,
    output logic [7:0] capture_b_low,
    output logic [7:0] capture_b_high
);
    import pwm_pkg::*;

    // ****************************************************************
    // Input synchronisers and edge detect
    // ****************************************************************
    logic [1:0] pin;
    logic [1:0] sync1_ff;
    logic [1:0] act;
    logic [1:0] act_q_ff;
    logic [1:0] rise;
    logic [3:0] mode [2];
    assign pin = {event_b_pin, event_a_pin};
    assign mode[0] = input_mode_select_a;
    assign mode[1] = input_mode_select_b;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_sync
            logic sync2_ff;
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    sync1_ff[g] <= 1'b0;
                    sync2_ff <= 1'b0;
                    act_q_ff[g] <= 1'b0;
                end
                else
                begin
                    sync1_ff[g] <= pin[g];
                    sync2_ff <= sync1_ff[g];
                    act_q_ff[g] <= sync2_ff;
                end
            end
            assign act[g] = sync2_ff;
            assign rise[g] = sync2_ff & ~act_q_ff[g];
        end
    endgenerate

    // ****************************************************************
    // Phase sequencer state
    // ****************************************************************
    pwm_phase_e phase_ff, nxt_phase;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic wait_ff, nxt_wait;
    logic halt_ff;
    logic [1:0] pend_ff, nxt_pend;
    logic [1:0] blk_ff;
    logic [DIT_W-1:0] acc_ff;
    logic dpend_ff;
    logic wave_a_ff;
    logic wave_b_ff;

    // Mode classes per input; codes above 10 fall in no class
    logic [1:0] own_hold, all_off, all_act, six_act, stop7;
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            own_hold[i] = act[i] && (mode[i] == IM_JUMP_WAIT || mode[i] == IM_EXEC_WAIT);
            all_act[i] = act[i] && (mode[i] == IM_DEAD_ONLY || mode[i] == IM_JUMP_ALL);
            six_act[i] = act[i] && mode[i] == IM_JUMP_ALL;
            stop7[i] = act[i] && mode[i] == IM_SW_WAIT;
            all_off[i] = all_act[i] || stop7[i] || (act[i] && mode[i] == IM_STOP_ALL);
        end
    end

    // ****************************************************************
    // Dither lengths
    // ****************************************************************
    logic dp, dead_sel, comp_a, comp_b;
    logic [3:0] ext, cut;
    logic [CNT_W:0] len_cur;
    logic [CNT_W-1:0] base;
    assign dp = dpend_ff && wave_gen != WG_DUAL;
    assign dead_sel = dither_placement == DP_DTB || dither_placement == DP_DTAB;
    assign comp_a = wave_gen == WG_ONE || (wave_gen == WG_TWO && dead_sel);
    assign comp_b = dead_sel && wave_gen != WG_FOUR;
    always_comb
    begin
        ext[PH_DTA] = dp && dither_placement == DP_DTAB;
        ext[PH_OTA] = dp && dither_placement == DP_OTAB;
        ext[PH_DTB] = dp && dead_sel;
        ext[PH_OTB] = dp && !dead_sel;
        cut[PH_DTA] = 1'b0;
        cut[PH_OTA] = ext[PH_DTA] && comp_a;
        cut[PH_DTB] = ext[PH_OTA] && comp_a;
        cut[PH_OTB] = ext[PH_DTB] && comp_b;
        case (phase_ff)
            PH_DTA: base = dead_a_len;
            PH_OTA: base = on_a_len;
            PH_DTB: base = dead_b_len;
            default: base = on_b_len;
        endcase
        len_cur = {1'b0, base} + {{CNT_W{1'b0}}, ext[phase_ff]} - {{CNT_W{1'b0}}, cut[phase_ff]};
        if (len_cur == '0)
            len_cur = {{CNT_W{1'b0}}, 1'b1};
    end

    // ****************************************************************
    // Next phase
    // ****************************************************************
    logic end_ph, hold, in_ot;
    assign end_ph = {1'b0, cnt_ff} >= len_cur - 1'b1;
    assign hold = (|own_hold) || (|six_act);
    assign in_ot = phase_ff[0];
    always_comb
    begin
        nxt_phase = phase_ff;
        nxt_cnt = cnt_ff + 1'b1;
        nxt_wait = wait_ff && hold;
        nxt_pend = pend_ff;
        if (wait_ff)
            nxt_cnt = cnt_ff;
        else
        begin
            if (end_ph)
            begin
                nxt_phase = pwm_phase_e'(phase_ff + 2'd1);
                nxt_cnt = RST_CNT;
                for (int i = 0; i < 2; i++)
                begin
                    if (phase_ff == pwm_phase_e'({~i[0], 1'b1}))
                    begin
                        if (act[i] && mode[i] == IM_EXEC_REP)
                            nxt_phase = pwm_phase_e'({~i[0], 1'b0});
                        if (pend_ff[i])
                        begin
                            nxt_wait = act[i];
                            nxt_pend[i] = 1'b0;
                        end
                    end
                end
                if (!in_ot && (|all_act))
                begin
                    nxt_phase = pwm_phase_e'({~phase_ff[1], 1'b0});
                    nxt_wait = |six_act;
                end
            end
            if (in_ot && (|all_act))
            begin
                nxt_phase = pwm_phase_e'({~phase_ff[1], 1'b0});
                nxt_cnt = RST_CNT;
                nxt_wait = |six_act;
            end
            for (int i = 1; i >= 0; i--)
            begin
                if (phase_ff[1] == i[0] && mode[i] != IM_NONE)
                begin
                    if (own_hold[i] && mode[i] == IM_JUMP_WAIT)
                    begin
                        nxt_phase = pwm_phase_e'({~i[0], 1'b0});
                        nxt_cnt = RST_CNT;
                        nxt_wait = 1'b1;
                    end
                    if (own_hold[i] && mode[i] == IM_EXEC_WAIT && !pend_ff[i])
                    begin
                        nxt_phase = pwm_phase_e'({~i[0], 1'b0});
                        nxt_cnt = RST_CNT;
                        nxt_pend[i] = 1'b1;
                    end
                    if (rise[i] && in_ot && mode[i] == IM_EDGE_JUMP)
                    begin
                        nxt_phase = pwm_phase_e'({~i[0], 1'b0});
                        nxt_cnt = RST_CNT;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_ff <= PH_DTA;
            cnt_ff <= RST_CNT;
            wait_ff <= 1'b0;
            pend_ff <= '0;
        end
        else if (halt_ff)
        begin
            if (restart_cmd)
            begin
                phase_ff <= PH_DTA;
                cnt_ff <= RST_CNT;
                wait_ff <= 1'b0;
                pend_ff <= '0;
            end
        end
        else
        begin
            phase_ff <= nxt_phase;
            cnt_ff <= nxt_cnt;
            wait_ff <= nxt_wait;
            pend_ff <= nxt_pend;
        end
    end

    // Stop on software-wait event; only restart leaves
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            halt_ff <= 1'b0;
        else if (|stop7)
            halt_ff <= 1'b1;
        else if (restart_cmd)
            halt_ff <= 1'b0;
    end

    // ****************************************************************
    // Dither accumulator
    // ****************************************************************
    logic [DIT_W:0] acc_sum;
    assign acc_sum = {1'b0, acc_ff} + {1'b0, dither_step};
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_ff <= RST_ACC;
            dpend_ff <= 1'b0;
        end
        else if (!halt_ff && !wait_ff && end_ph && phase_ff == PH_OTB && nxt_phase == PH_DTA)
        begin
            acc_ff <= acc_sum[DIT_W-1:0];
            dpend_ff <= acc_sum[DIT_W];
        end
    end

    // ****************************************************************
    // Output blanking
    // ****************************************************************
    logic [1:0] own_ot, off;
    generate
        for (g = 0; g < 2; g++)
        begin : g_blank
            assign own_ot[g] = phase_ff == pwm_phase_e'({1'(g), 1'b1});
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    blk_ff[g] <= 1'b0;
                else if (own_ot[g] && rise[g] && mode[g] == IM_EDGE_BLANK)
                    blk_ff[g] <= 1'b1;
                else if (own_ot[g] && act[g] && mode[g] == IM_LEVEL_BLANK)
                    blk_ff[g] <= 1'b1;
                else if (!own_ot[g])
                    blk_ff[g] <= 1'b0;
            end
            assign off[g] = halt_ff || wait_ff || (|all_off) || blk_ff[g] || own_hold[g]
                || (act[g] && mode[g] == IM_LEVEL_BLANK);
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wave_a_ff <= 1'b0;
            wave_b_ff <= 1'b0;
        end
        else
        begin
            wave_a_ff <= own_ot[0] && !off[0];
            wave_b_ff <= own_ot[1] && !off[1];
        end
    end
    assign wave_out_a = wave_a_ff;
    assign wave_out_b = wave_b_ff;

    // ****************************************************************
    // Capture units
    // ****************************************************************
    pwm_cap_if cap_a ();
    pwm_cap_if cap_b ();
    assign cap_a.trig = software_capture_strobe[0] | (capture_on_event[0] & rise[0]);
    assign cap_b.trig = software_capture_strobe[1] | (capture_on_event[1] & rise[1]);
    assign cap_a.value = cnt_ff;
    assign cap_b.value = cnt_ff;
    assign cap_a.rd_low = capture_low_read[0];
    assign cap_b.rd_low = capture_low_read[1];
    assign cap_a.clr = trigger_clear[0];
    assign cap_b.clr = trigger_clear[1];
    pwm_capture u_cap_a (.clk(clk), .rst_n(rst_n), .cap(cap_a.unit));
    pwm_capture u_cap_b (.clk(clk), .rst_n(rst_n), .cap(cap_b.unit));
    assign command_ready = !cap_a.busy && !cap_b.busy;
    assign trigger_flag_a = cap_a.flag;
    assign trigger_flag_b = cap_b.flag;
    assign trigger_irq = |({cap_b.flag, cap_a.flag} & trigger_irq_enable);
    assign capture_a_low = cap_a.low;
    assign capture_a_high = cap_a.high;
    assign capture_b_low = cap_b.low;
    assign capture_b_high = cap_b.high;

    // ****************************************************************
    // Checks
    // ****************************************************************
    mode0_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode[0] == IM_NONE && mode[1] == IM_NONE && !halt_ff && !wait_ff)
        |=> wave_a_ff == $past(phase_ff == PH_OTA && !blk_ff[0]))
        else $error("mode 0 changed output a");
    mode1_jump_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!halt_ff && !wait_ff && mode[1] == IM_NONE && own_hold[0] && mode[0] == IM_JUMP_WAIT
        && phase_ff[1] == 1'b0) |=> phase_ff == PH_DTB && wait_ff && cnt_ff == '0)
        else $error("mode 1 did not jump to dead time b");
    stop_all_a: assert property (@(posedge clk) disable iff (!rst_n)
        (act[0] && mode[0] == IM_STOP_ALL) |=> !wave_a_ff && !wave_b_ff)
        else $error("mode 4 left an output on");
    halt_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (halt_ff && !restart_cmd) |=> $stable(cnt_ff) && $stable(phase_ff) && halt_ff)
        else $error("counter moved while stopped");
    restart_dta_a: assert property (@(posedge clk) disable iff (!rst_n)
        (halt_ff && restart_cmd) |=> phase_ff == PH_DTA && cnt_ff == '0)
        else $error("restart did not begin at dead time a");
    edge_blank_a: assert property (@(posedge clk) disable iff (!rst_n)
        (own_ot[0] && rise[0] && mode[0] == IM_EDGE_BLANK) |=> blk_ff[0])
        else $error("mode 9 edge not blanked");
    level_blank_a: assert property (@(posedge clk) disable iff (!rst_n)
        (act[1] && mode[1] == IM_LEVEL_BLANK) |=> !wave_b_ff)
        else $error("mode 10 output b on while active");
    dither_add_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wave_gen == WG_DUAL) |-> ext == 4'h0)
        else $error("dither applied in dual slope");
    cov_wait: cover property (@(posedge clk) disable iff (!rst_n) wait_ff ##1 !wait_ff);
    cov_halt: cover property (@(posedge clk) disable iff (!rst_n) halt_ff && restart_cmd);
    cov_dith: cover property (@(posedge clk) disable iff (!rst_n) dp && phase_ff == PH_OTB);
endmodule // pwm_fault_dither_capture

// *** tb/pwm_far_model.sv ***
// Far-side model: fault sources on the event pins and a half-bridge load.
// Assumes one clock; the bench asks for fault levels.
`timescale 1ns/1ps
module pwm_far_model
(
    input wire logic clk,
    input wire logic fault_a_req,
    input wire logic fault_b_req,
    input wire logic wave_out_a,
    input wire logic wave_out_b,
    output logic event_a_pin = 1'b0,
    output logic event_b_pin = 1'b0,
    output logic bridge_short
);
    // Fault levels are held for as long as the bench asks
    always @(posedge clk)
    begin
        event_a_pin <= fault_a_req;
        event_b_pin <= fault_b_req;
    end
    assign bridge_short = wave_out_a & wave_out_b;
endmodule // pwm_far_model

// *** tb/pwm_fault_dither_capture_test.sv ***
// Self-checking bench for the PWM fault, dither and capture block.
// Assumes the far-side model drives the event pins.
`timescale 1ns/1ps
module pwm_fault_dither_capture_test;
    import pwm_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, fa = 1'b0, fb = 1'b0, restart_cmd = 1'b0, ev_a, ev_b, shorted;
    logic [3:0] mode_a = IM_NONE, mode_b = IM_NONE;
    logic [1:0] coe = 2'h0, swc = 2'h0, clr = 2'h0, irq_en = 2'h0, low_rd = 2'h0;
    logic wa, wb, rdy, fla, flb, irq;
    logic [7:0] al, ah, bl, bh;
    logic [7:0] dstep = 8'h00;
    int failures = 0, samples_checked = 0;
    pwm_far_model far (.clk(clk), .fault_a_req(fa), .fault_b_req(fb), .wave_out_a(wa),
        .wave_out_b(wb), .event_a_pin(ev_a), .event_b_pin(ev_b), .bridge_short(shorted));
    pwm_fault_dither_capture DUT (.clk(clk), .rst_n(rst_n), .event_a_pin(ev_a),
        .event_b_pin(ev_b), .input_mode_select_a(mode_a), .input_mode_select_b(mode_b),
        .wave_gen(WG_TWO), .dead_a_len(16'h0003), .on_a_len(16'h0004), .dead_b_len(16'h0003),
        .on_b_len(16'h0004), .dither_placement(DP_OTB), .dither_step(dstep),
        .capture_on_event(coe), .software_capture_strobe(swc), .restart_cmd(restart_cmd),
        .trigger_clear(clr), .trigger_irq_enable(irq_en), .capture_low_read(low_rd),
        .wave_out_a(wa), .wave_out_b(wb), .command_ready(rdy), .trigger_flag_a(fla),
        .trigger_flag_b(flb), .trigger_irq(irq), .capture_a_low(al), .capture_a_high(ah),
        .capture_b_low(bl), .capture_b_high(bh));
    initial
    begin
        forever #50 clk = ~clk;
    end
    // ****************************************
    // Shared checks and waits
    // ****************************************
    task automatic expect_bit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_a(input logic lvl);
        int n;
        n = 0;
        #1;
        while (wa !== lvl && n < 60)
        begin
            tick(1);
            n++;
        end
        expect_bit(wa, lvl, "wave a level not reached");
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic no_action_capture();
        @(posedge clk) coe <= 2'h1;
        fa <= 1'b1;
        tick(8);
        expect_bit(fla, 1'b1, "event capture flag");
        expect_bit(al < 8'h04 && ah === 8'h00, 1'b1, "capture a value");
        wait_a(1'b1);
        wait_a(1'b0);
        expect_bit(shorted, 1'b0, "both outputs high");
        @(posedge clk) fa <= 1'b0;
        clr <= 2'h1;
        @(posedge clk) clr <= 2'h0;
        coe <= 2'h0;
        tick(1);
        expect_bit(fla, 1'b0, "flag a not cleared");
        $display("test no_action_capture done");
    endtask
    task automatic software_capture();
        @(posedge clk) swc <= 2'h2;
        irq_en <= 2'h2;
        @(posedge clk) swc <= 2'h0;
        #1;
        expect_bit(rdy, 1'b0, "ready during capture");
        tick(3);
        expect_bit(rdy, 1'b1, "ready after capture");
        expect_bit(flb, 1'b1, "flag b after capture");
        expect_bit(irq, 1'b1, "trigger interrupt");
        @(posedge clk) low_rd <= 2'h2;
        @(posedge clk) low_rd <= 2'h0;
        tick(1);
        expect_bit(bl < 8'h04 && bh === 8'h00, 1'b1, "capture b value");
        $display("test software_capture done");
    endtask
    task automatic blank_run(input logic [3:0] m);
        @(posedge clk) mode_a <= m;
        fa <= 1'b1;
        tick(m == IM_EXEC_REP ? 10 : 5);
        repeat (16)
        begin
            expect_bit(wa, 1'b0, "wave a while fault");
            if (m == IM_STOP_ALL || m == IM_DEAD_ONLY || m == IM_JUMP_ALL)
                expect_bit(wb, 1'b0, "wave b while fault");
            tick(1);
        end
        if (m == IM_SW_WAIT)
        begin
            @(posedge clk) restart_cmd <= 1'b1;
            @(posedge clk) restart_cmd <= 1'b0;
            @(posedge clk) fa <= 1'b0;
            tick(20);
            expect_bit(wa, 1'b0, "ran before restart");
            @(posedge clk) restart_cmd <= 1'b1;
            @(posedge clk) restart_cmd <= 1'b0;
        end
        @(posedge clk) fa <= 1'b0;
        wait_a(1'b1);
        $display("test blank_run mode %0d done", m);
    endtask
    task automatic reserved_mode();
        @(posedge clk) mode_a <= 4'hc;
        fa <= 1'b1;
        wait_a(1'b0);
        wait_a(1'b1);
        @(posedge clk) fa <= 1'b0;
        $display("test reserved_mode done");
    endtask
    // Edge lands one cycle into on time a
    task automatic edge_run(input logic [3:0] m);
        @(posedge clk) mode_a <= m;
        wait_a(1'b1);
        wait_a(1'b0);
        tick(6);
        @(posedge clk) fa <= 1'b1;
        tick(5);
        expect_bit(wa, 1'b0, "edge did not end on time a");
        tick(3);
        expect_bit(wb, m == IM_EDGE_JUMP, "counter flow after edge");
        @(posedge clk) fa <= 1'b0;
        $display("test edge_run mode %0d done", m);
    endtask
    task automatic dither_run();
        int n;
        n = 0;
        @(posedge clk) dstep <= 8'hff;
        tick(40);
        wait_a(1'b1);
        while (wb !== 1'b1 && n < 20)
        begin
            tick(1);
            n++;
        end
        n = 0;
        while (wb === 1'b1 && n < 20)
        begin
            tick(1);
            n++;
        end
        expect_bit(n == 5, 1'b1, "on time b not stretched");
        @(posedge clk) dstep <= 8'h00;
        $display("test dither_run done");
    endtask
    initial
    begin
        tick(6);
        expect_bit(rdy, 1'b1, "ready in reset");
        expect_bit(wa | fla, 1'b0, "outputs in reset");
        @(posedge clk) rst_n <= 1'b1;
        tick(2);
        no_action_capture();
        software_capture();
        blank_run(IM_STOP_ALL);
        blank_run(IM_LEVEL_BLANK);
        blank_run(IM_SW_WAIT);
        blank_run(IM_JUMP_WAIT);
        blank_run(IM_EXEC_WAIT);
        blank_run(IM_EXEC_REP);
        blank_run(IM_DEAD_ONLY);
        blank_run(IM_JUMP_ALL);
        reserved_mode();
        edge_run(IM_EDGE_JUMP);
        edge_run(IM_EDGE_BLANK);
        dither_run();
        finish_test();
    end
endmodule // pwm_fault_dither_capture_test
